//--- hdl/gdfp_consts.svh
/*
 Constants for the gate driver fault supervisor: offsets, reset values, times.
 Assumes a 20 MHz pclk; all counts derive from the clock period below.
*/
`ifndef GDFP_CONSTS_SVH
`define GDFP_CONSTS_SVH
`define GDFP_CLK_NS 50
`define GDFP_CYC_UP(ns) ((((ns) + `GDFP_CLK_NS - 1) / `GDFP_CLK_NS))
`define GDFP_ADDR_W 12
`define GDFP_SYNC_RST 25'h0000006
`define GDFP_OFS_STATUS 12'h000
`define GDFP_OFS_CTRL 12'h004
`define GDFP_OFS_GATES 12'h008
`define GDFP_CTRL_RST 21'h000000
`define GDFP_OCP_HW_NS 4000
`define GDFP_DEG0_NS 1000
`define GDFP_DEG1_NS 2000
`define GDFP_DEG2_NS 4000
`define GDFP_DEG3_NS 8000
`define GDFP_DRIVE_NS 4000
`define GDFP_RETRY_NS 4000000
`define GDFP_CNT_W 12
`define GDFP_RETRY_W 20
`define GDFP_MODE_HB 3'h3
`define GDFP_MODE_FET_BIT 2
`endif

//--- hdl/gdfp_pkg.sv
/*
 Types shared by the fault supervisor: control word, status word, overcurrent modes.
 Assumes the control struct layout is the control register layout, low bit last.
*/
package gdfp_pkg;
    typedef enum logic [1:0] {GDFP_OC_LATCH, GDFP_OC_RETRY, GDFP_OC_REPORT, GDFP_OC_OFF} gdfp_ocm_e;

    typedef struct packed {
        logic [2:0] phase_fet;
        logic [2:0] phase_hb;
        logic [2:0] bridge_mode;
        logic [2:0] per_phase_oc_disable;
        logic [1:0] overcurrent_deglitch_sel;
        logic [1:0] overcurrent_mode;
        logic thermal_recovery_mode;
        logic warn_to_fault_pin;
        logic gate_fault_disable;
        logic pump_uv_disable;
        logic clear_faults_cmd;
    } gdfp_ctrl_s;

    typedef struct packed {
        logic [5:0] per_gate_fault_flag;
        logic [5:0] per_fet_oc_flag;
        logic thermal_shutdown;
        logic thermal_warning;
        logic gate_drive_fault;
        logic overcurrent_flag;
        logic pump_uv_flag;
        logic supply_uv_flag;
        logic global_fault_flag;
    } gdfp_stat_s;
endpackage

//--- hdl/gdfp_hold_cnt.sv
/*
 Persistence counter: flags a level that has held without a break for a limit.
 Assumes the level is already synchronous to pclk and the limit is stable.
*/
`timescale 1ns/1ns
`include "gdfp_consts.svh"
module gdfp_hold_cnt #(
    parameter int W = `GDFP_CNT_W
)(
    input logic pclk,
    input logic presetn,
    input logic active,
    input logic [W-1:0] limit,
    output logic hit
);
    logic [W-1:0] cnt_reg;
    logic [W-1:0] cnt_next;
    logic hit_reg;
    logic hit_next;

    // count while active, restart on any break, saturate at the limit
    always_comb begin
        cnt_next = '0;
        hit_next = 1'b0;
        if (active) begin
            cnt_next = (cnt_reg >= limit) ? cnt_reg : cnt_reg + 1'b1;
            hit_next = (cnt_reg >= limit);
        end
    end

    // state registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_reg <= '0;
            hit_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            hit_reg <= hit_next;
        end
    end

    assign hit = hit_reg;
endmodule

//--- hdl/gdfp_top.sv
/*
 Fault supervisor for a three half-bridge gate driver, with an APB register slave.
 Assumes analog comparators arrive as asynchronous levels and gate senses high
 mean the gate has reached the high level.
*/
`timescale 1ns/1ns
`include "gdfp_consts.svh"
module gdfp_top #(
    parameter int RETRY_CYC = `GDFP_CYC_UP(`GDFP_RETRY_NS),
    parameter bit HW_VARIANT = 1'b0
)(
    input logic pclk,
    input logic presetn,
    input logic psel,
    input logic penable,
    input logic pwrite,
    input logic [`GDFP_ADDR_W-1:0] paddr,
    input logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input logic supply_uv_in,
    input logic pump_uv_in,
    input logic otw_in,
    input logic thermal_shutdown_in,
    input logic [5:0] vds_trip_in,
    input logic [5:0] gate_sense_in,
    input logic [5:0] pwm_in,
    input logic enable_pin,
    input logic low_power_pin,
    input logic hw_oc_disable_pin,
    output logic [2:0] high_gate_out,
    output logic [2:0] low_gate_out,
    output logic pump_enable,
    output logic fault_out_o,
    output logic fault_out_oe,
    output gdfp_pkg::gdfp_stat_s fault_status
);
    import gdfp_pkg::*;

    localparam int SW = 25;
    localparam logic [`GDFP_CNT_W-1:0] DEG_HW = `GDFP_CNT_W'(`GDFP_CYC_UP(`GDFP_OCP_HW_NS));
    localparam logic [`GDFP_CNT_W-1:0] DEG0 = `GDFP_CNT_W'(`GDFP_CYC_UP(`GDFP_DEG0_NS));
    localparam logic [`GDFP_CNT_W-1:0] DEG1 = `GDFP_CNT_W'(`GDFP_CYC_UP(`GDFP_DEG1_NS));
    localparam logic [`GDFP_CNT_W-1:0] DEG2 = `GDFP_CNT_W'(`GDFP_CYC_UP(`GDFP_DEG2_NS));
    localparam logic [`GDFP_CNT_W-1:0] DEG3 = `GDFP_CNT_W'(`GDFP_CYC_UP(`GDFP_DEG3_NS));
    localparam logic [`GDFP_CNT_W-1:0] DRV_LIM = `GDFP_CNT_W'(`GDFP_CYC_UP(`GDFP_DRIVE_NS));
    localparam logic [`GDFP_RETRY_W-1:0] RETRY_LAST = `GDFP_RETRY_W'(RETRY_CYC - 1);

    logic [SW-1:0] sync1_reg;
    logic [SW-1:0] sync2_reg;
    logic [5:0] pwm_s;
    logic [5:0] vds_s;
    logic [5:0] sense_s;
    logic supply_uv_s, pump_uv_s, otw_s, thermal_shutdown_s, en_s, lp_s, hwdis_s;
    logic en_prev_reg, lp_prev_reg;
    gdfp_ctrl_s ctrl_reg, ctrl_next;
    gdfp_stat_s stat_reg, stat_next;
    logic [31:0] prdata_reg, prdata_next;
    logic pready_reg, pready_next;
    logic pslverr_reg, pslverr_next;
    logic supply_uv_reg, supply_uv_next;
    logic pump_uv_reg, pump_uv_next;
    logic otw_reg, otw_next;
    logic thermal_shutdown_reg, thermal_shutdown_next;
    logic [5:0] oc_reg, oc_next;
    logic [5:0] gf_reg, gf_next;
    logic [`GDFP_RETRY_W-1:0] retry_reg, retry_next;
    logic [5:0] drv_reg, drv_next;
    logic pump_reg, pump_next;
    logic fault_reg, fault_next;
    logic zero_reg;
    logic [5:0] oc_hit;
    logic [5:0] gf_hit;
    logic [5:0] oc_watch;
    logic [5:0] mismatch;
    logic [5:0] gf_mask;
    logic [`GDFP_CNT_W-1:0] deg_lim;
    gdfp_ocm_e ocm;
    logic clr_pulse, clr_thermal, retry_done, thermal_shutdown_active, gf_all, all_off, wr_acc;

    // two-flop synchroniser for every pin level
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_reg <= `GDFP_SYNC_RST;  // enable and sleep pins idle high
            sync2_reg <= `GDFP_SYNC_RST;
        end else begin
            sync1_reg <= {pwm_in, vds_trip_in, gate_sense_in, supply_uv_in, pump_uv_in,
                          otw_in, thermal_shutdown_in, enable_pin, low_power_pin, hw_oc_disable_pin};
            sync2_reg <= sync1_reg;
        end
    end

    assign {pwm_s, vds_s, sense_s, supply_uv_s, pump_uv_s, otw_s, thermal_shutdown_s, en_s, lp_s, hwdis_s}
        = sync2_reg;

    // reset pulses end on the rising edge of the pin; clear command is one cycle
    assign clr_pulse = ctrl_reg.clear_faults_cmd | (en_s & ~en_prev_reg);
    assign clr_thermal = ctrl_reg.clear_faults_cmd | (lp_s & ~lp_prev_reg);

    // effective overcurrent mode and deglitch limit
    always_comb begin
        ocm = gdfp_ocm_e'(ctrl_reg.overcurrent_mode);
        if (HW_VARIANT) begin
            ocm = hwdis_s ? GDFP_OC_OFF : GDFP_OC_LATCH;
        end
        unique case (ctrl_reg.overcurrent_deglitch_sel)
            2'h0: deg_lim = DEG0;
            2'h1: deg_lim = DEG1;
            2'h2: deg_lim = DEG2;
            2'h3: deg_lim = DEG3;
        endcase
        if (HW_VARIANT) begin
            deg_lim = DEG_HW;
        end
    end

    // per-fet monitors: overcurrent deglitch and gate slew timeout
    generate
        for (genvar i = 0; i < 6; i++) begin : g_mon
            assign oc_watch[i] = vds_s[i] & drv_reg[i] & ~ctrl_reg.per_phase_oc_disable[i/2]
                                 & (ocm != GDFP_OC_OFF);
            assign mismatch[i] = drv_reg[i] ^ sense_s[i];
            gdfp_hold_cnt #(.W(`GDFP_CNT_W)) u_oc (
                .pclk(pclk),
                .presetn(presetn),
                .active(oc_watch[i]),
                .limit(deg_lim),
                .hit(oc_hit[i])
            );
            gdfp_hold_cnt #(.W(`GDFP_CNT_W)) u_gf (
                .pclk(pclk),
                .presetn(presetn),
                .active(mismatch[i]),
                .limit(DRV_LIM),
                .hit(gf_hit[i])
            );
        end
    endgenerate

    // thermal shutdown holds until cleared in mode 0, follows the sensor in mode 1
    assign thermal_shutdown_active = ctrl_reg.thermal_recovery_mode ? thermal_shutdown_s : thermal_shutdown_reg;
    assign retry_done = (ocm == GDFP_OC_RETRY) && (|oc_reg) && (retry_reg == RETRY_LAST);

    // fault flags; a set always wins over a clear in the same cycle
    always_comb begin
        supply_uv_next = supply_uv_s | (supply_uv_reg & ~(clr_pulse & ~supply_uv_s));
        pump_uv_next = (pump_uv_s & ~thermal_shutdown_active)
                       | (pump_uv_reg & ~(clr_pulse & ~pump_uv_s));
        otw_next = otw_s;
        thermal_shutdown_next = thermal_shutdown_s | (thermal_shutdown_reg & ~(clr_thermal & ~thermal_shutdown_s));
        for (int i = 0; i < 6; i++) begin
            if (ocm == GDFP_OC_RETRY) begin
                oc_next[i] = oc_hit[i] | (oc_reg[i] & ~retry_done);
            end else begin
                oc_next[i] = oc_hit[i] | (oc_reg[i] & ~(clr_pulse & ~vds_s[i]));
            end
            gf_next[i] = gf_hit[i] | (gf_reg[i] & ~(clr_pulse & ~mismatch[i]));
        end
        if (ocm == GDFP_OC_OFF) begin
            oc_next = '0;
        end
        retry_next = '0;
        if ((ocm == GDFP_OC_RETRY) && (|oc_reg) && !retry_done) begin
            retry_next = retry_reg + 1'b1;
        end
    end

    // shutdown scope of a gate fault by bridge mode and per-phase setting
    always_comb begin
        gf_all = 1'b0;
        gf_mask = '0;
        for (int i = 0; i < 6; i++) begin
            if (gf_reg[i] && !ctrl_reg.gate_fault_disable) begin
                if (ctrl_reg.bridge_mode[`GDFP_MODE_FET_BIT] || ctrl_reg.phase_fet[i/2]) begin
                    gf_mask[i] = 1'b1;
                end else if ((ctrl_reg.bridge_mode == `GDFP_MODE_HB) || ctrl_reg.phase_hb[i/2]) begin
                    gf_mask[(i/2)*2] = 1'b1;
                    gf_mask[(i/2)*2+1] = 1'b1;
                end else begin
                    gf_all = 1'b1;
                end
            end
        end
    end

    // gate, pump and fault pin drive
    always_comb begin
        all_off = supply_uv_s
                  | (pump_uv_s & ~ctrl_reg.pump_uv_disable)
                  | ((|oc_reg) & ((ocm == GDFP_OC_LATCH) | (ocm == GDFP_OC_RETRY)))
                  | thermal_shutdown_active | gf_all;
        drv_next = all_off ? 6'h00 : (pwm_s & ~gf_mask);
        pump_next = ~supply_uv_s & ~thermal_shutdown_active;
        fault_next = supply_uv_s | (pump_uv_s & ~ctrl_reg.pump_uv_disable)
                     | (|oc_reg)
                     | ((|gf_reg) & ~ctrl_reg.gate_fault_disable)
                     | (otw_reg & ctrl_reg.warn_to_fault_pin)
                     | thermal_shutdown_active;
    end

    // status word; global flag is the OR of every individual flag
    always_comb begin
        stat_next.per_gate_fault_flag = gf_reg;
        stat_next.per_fet_oc_flag = oc_reg;
        stat_next.thermal_shutdown = thermal_shutdown_reg;
        stat_next.thermal_warning = otw_reg;
        stat_next.gate_drive_fault = |gf_reg;
        stat_next.overcurrent_flag = |oc_reg;
        stat_next.pump_uv_flag = pump_uv_reg;
        stat_next.supply_uv_flag = supply_uv_reg;
        stat_next.global_fault_flag = supply_uv_reg | pump_uv_reg | (|oc_reg) | (|gf_reg)
                                      | otw_reg | thermal_shutdown_reg;
    end

    // apb slave: answer prepared in setup, access phase takes one cycle
    assign wr_acc = psel & penable & pready_reg & pwrite;
    always_comb begin
        ctrl_next = ctrl_reg;
        ctrl_next.clear_faults_cmd = 1'b0;
        if (wr_acc && (paddr == `GDFP_OFS_CTRL)) begin
            ctrl_next = gdfp_ctrl_s'(pwdata[$bits(gdfp_ctrl_s)-1:0]);
            if (ocm == GDFP_OC_OFF) begin
                ctrl_next.per_phase_oc_disable = ctrl_reg.per_phase_oc_disable;
            end
        end
        pready_next = psel & ~penable;
        pslverr_next = 1'b0;
        prdata_next = 32'h00000000;
        if (psel && !penable) begin
            unique case (paddr)
                `GDFP_OFS_STATUS: prdata_next = 32'(stat_reg);
                `GDFP_OFS_CTRL: prdata_next = 32'(ctrl_reg);
                `GDFP_OFS_GATES: prdata_next = {25'h0000000, pump_reg, drv_reg};
                default: pslverr_next = 1'b1;
            endcase
        end
    end

    // state registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_prev_reg <= 1'b1;  // no false reset pulse after reset
            lp_prev_reg <= 1'b1;
            ctrl_reg <= gdfp_ctrl_s'(`GDFP_CTRL_RST);
            stat_reg <= '0;
            prdata_reg <= 32'h00000000;
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            supply_uv_reg <= 1'b0;
            pump_uv_reg <= 1'b0;
            otw_reg <= 1'b0;
            thermal_shutdown_reg <= 1'b0;
            oc_reg <= 6'h00;
            gf_reg <= 6'h00;
            retry_reg <= '0;
            drv_reg <= 6'h00;
            pump_reg <= 1'b0;
            fault_reg <= 1'b0;
            zero_reg <= 1'b0;
        end else begin
            en_prev_reg <= en_s;
            lp_prev_reg <= lp_s;
            ctrl_reg <= ctrl_next;
            stat_reg <= stat_next;
            prdata_reg <= prdata_next;
            pready_reg <= pready_next;
            pslverr_reg <= pslverr_next;
            supply_uv_reg <= supply_uv_next;
            pump_uv_reg <= pump_uv_next;
            otw_reg <= otw_next;
            thermal_shutdown_reg <= thermal_shutdown_next;
            oc_reg <= oc_next;
            gf_reg <= gf_next;
            retry_reg <= retry_next;
            drv_reg <= drv_next;
            pump_reg <= pump_next;
            fault_reg <= fault_next;
            zero_reg <= 1'b0;
        end
    end

    // outputs straight from registers; fet 2p is high side, 2p+1 low side
    assign high_gate_out = {drv_reg[4], drv_reg[2], drv_reg[0]};
    assign low_gate_out = {drv_reg[5], drv_reg[3], drv_reg[1]};
    assign pump_enable = pump_reg;
    assign fault_out_o = zero_reg;
    assign fault_out_oe = fault_reg;  // pulls the open-drain pin low
    assign fault_status = stat_reg;
    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
endmodule

//--- bench/gdfp_fet_model.sv
/*
 Partner model: external half-bridge FETs whose gates slew behind the drive.
 Assumes stuck bits model gates shorted low, set by the gate fault tests.
*/
`timescale 1ns/1ns
module gdfp_fet_model (
    input logic pclk,
    input logic presetn,
    input logic [2:0] high_gate_out,
    input logic [2:0] low_gate_out,
    input logic [5:0] stuck,
    output logic [5:0] gate_sense_in
);
    logic [5:0] slew_reg;
    logic [5:0] slew_next;
    // a shorted gate never leaves the low level
    always_comb begin
        slew_next = {low_gate_out[2], high_gate_out[2], low_gate_out[1], high_gate_out[1],
            low_gate_out[0], high_gate_out[0]} & ~stuck;
    end
    // two cycles of slewing before the sense follows
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            slew_reg <= 6'h00;
            gate_sense_in <= 6'h00;
        end else begin
            slew_reg <= slew_next;
            gate_sense_in <= slew_reg;
        end
    end
endmodule

//--- bench/gdfp_top_sva.sv
/*
 Checker for the fault supervisor: bus handshake and fault responses.
 Assumes it is bound into gdfp_top and sees its ports only.
*/
`timescale 1ns/1ns
module gdfp_top_sva #(
    parameter int RETRY_CYC = 50
)(
    input logic pclk,
    input logic presetn,
    input logic psel,
    input logic penable,
    input logic [11:0] paddr,
    input logic [31:0] prdata,
    input logic pready,
    input logic pslverr,
    input logic supply_uv_in,
    input logic pump_uv_in,
    input logic thermal_shutdown_in,
    input logic [5:0] pwm_in,
    input logic [2:0] high_gate_out,
    input logic [2:0] low_gate_out,
    input logic pump_enable,
    input logic fault_out_oe,
    input gdfp_pkg::gdfp_stat_s fault_status
);
    import gdfp_pkg::*;
    logic [5:0] gv;
    logic held;
    // gates in sense-bit order; any latched flag
    assign gv = {low_gate_out[2], high_gate_out[2], low_gate_out[1], high_gate_out[1],
        low_gate_out[0], high_gate_out[0]};
    assign held = |{fault_status[18:6], fault_status[4:1]};
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    a_uv_off: assert property (
        supply_uv_in [*6] |-> gv == 6'h00 && !pump_enable && fault_out_oe)
        else $error("supply low but drive on");
    a_uv_flag: assert property (
        supply_uv_in [*6] |-> fault_status.supply_uv_flag && fault_status.global_fault_flag)
        else $error("supply flag missing");
    a_pump_flag: assert property (
        (pump_uv_in && !fault_status.thermal_shutdown && !supply_uv_in) [*6]
        |-> fault_status.pump_uv_flag)
        else $error("pump flag missing");
    a_thermal_shutdown_off: assert property (
        thermal_shutdown_in [*6] |-> gv == 6'h00 && !pump_enable && fault_out_oe
        && fault_status.thermal_shutdown)
        else $error("hot but drive on");
    a_global_set: assert property (
        held |-> fault_status.global_fault_flag)
        else $error("global flag missing");
    a_global_cause: assert property (
        fault_status.global_fault_flag |-> held || fault_status.thermal_warning)
        else $error("global flag without cause");
    a_ready_once: assert property (
        psel && !penable |=> pready ##1 !pready)
        else $error("ready not one cycle");
    a_unmapped_err: assert property (
        psel && !penable && paddr[11:4] != 8'h00 |=> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    a_drive_follow: assert property (
        (!fault_out_oe && $stable(pwm_in)) [*8] |-> $past(gv, 2) == pwm_in)
        else $error("gates ignore command");
    a_pin_cause: assert property (
        $rose(fault_out_oe) |-> ##[0:2] (fault_status.global_fault_flag
        || fault_status.thermal_warning))
        else $error("pin low without flag");
endmodule
bind gdfp_top gdfp_top_sva #(.RETRY_CYC(RETRY_CYC)) sva_u (.*);

//--- bench/gdfp_top_tb.sv
/*
 Bench for gdfp_top: registers and each fault response.
 Assumes the FET model closes the gate sense loop.
*/
`timescale 1ns/1ns
module gdfp_top_tb;
    import gdfp_pkg::*;
    localparam int RC = 50;
    localparam logic [15:0] GATE_DRIVE_FAULT [11] = '{{1'b0, 9'h000, 6'h00}, {1'b0, 9'h040, 6'h00},
        {1'b0, 9'h080, 6'h00}, {1'b0, 9'h0c0, 6'h33}, {1'b0, 9'h100, 6'h3b},
        {1'b0, 9'h140, 6'h3b}, {1'b0, 9'h180, 6'h3b}, {1'b0, 9'h1c0, 6'h3b},
        {1'b0, 9'h010, 6'h33}, {1'b0, 9'h002, 6'h3b}, {1'b1, 9'h000, 6'h3f}};
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic supply_uv_in = 1'b0, pump_uv_in = 1'b0, otw_in = 1'b0, thermal_shutdown_in = 1'b0;
    logic enable_pin = 1'b1, low_power_pin = 1'b1, hw_oc_disable_pin = 1'b0;
    logic pready, pslverr, pump_enable, fault_out_o, fault_out_oe, e;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic [5:0] vds_trip_in = 6'h00, pwm_in = 6'h15, stuck = 6'h00, gate_sense_in;
    logic [2:0] high_gate_out, low_gate_out;
    gdfp_stat_s fault_status;
    gdfp_ctrl_s cfg = '0;
    int err_total = 0, n_checks = 0;
    wire [5:0] gv = {low_gate_out[2], high_gate_out[2], low_gate_out[1], high_gate_out[1],
        low_gate_out[0], high_gate_out[0]};
    // clock, design and far side
    always #25 pclk = ~pclk;
    gdfp_top #(.RETRY_CYC(RC)) dut_u (.*);
    gdfp_fet_model fet_u (.*);
    // pin-strapped variant on the same pins, with ideal gate sensing
    logic [2:0] hw_hi, hw_lo;
    logic hw_oe;
    gdfp_stat_s hw_st;
    wire [5:0] hw_gv = {hw_lo[2], hw_hi[2], hw_lo[1], hw_hi[1], hw_lo[0], hw_hi[0]};
    gdfp_top #(.RETRY_CYC(RC), .HW_VARIANT(1'b1)) hw_u (.*, .prdata(), .pready(), .pslverr(),
        .gate_sense_in(hw_gv), .high_gate_out(hw_hi), .low_gate_out(hw_lo), .pump_enable(),
        .fault_out_o(), .fault_out_oe(hw_oe), .fault_status(hw_st));
    task automatic chk(input string w, input logic [31:0] s, input logic [31:0] x);
        n_checks++;
        if (s !== x) begin
            err_total++;
            $display("BAD %s expected %h seen %h", w, x, s);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task automatic outs(input logic [5:0] g, input logic p, input logic f);
        chk("outs", {gv, pump_enable, fault_out_oe}, {g, p, f});
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1);
        chk("ready", k, 1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic put();
        apb(1'b1, 12'h004, {11'h0, cfg});
    endtask
    task automatic clr();
        apb(1'b1, 12'h004, {11'h0, cfg} | 32'h1);
        tick(6);
    endtask
    task automatic t_regs();
        apb(1'b0, 12'h004, 32'h0);
        chk("ctrl rst", q, 32'h0);
        apb(1'b0, 12'h008, 32'h0);
        chk("gates", q, 32'h55);
        cfg.pump_uv_disable = 1'b1;
        clr();
        apb(1'b0, 12'h004, 32'h0);
        chk("ctrl", q, 32'h2);
        apb(1'b1, 12'h000, 32'hffffffff);
        apb(1'b0, 12'h100, 32'h0);
        chk("unmapped", {e, q[30:0]}, 32'h80000000);
        apb(1'b0, 12'h000, 32'h0);
        chk("status", q, 32'h0);
        chk("pin level", fault_out_o, 1'b0);
    endtask
    task automatic t_sup();
        supply_uv_in <= 1'b1;
        tick(8);
        outs(6'h00, 1'b0, 1'b1);
        apb(1'b0, 12'h000, 32'h0);
        chk("status uv", q, 32'h3);
        supply_uv_in <= 1'b0;
        tick(8);
        outs(6'h15, 1'b1, 1'b0);
        chk("uv held", fault_status.supply_uv_flag, 1'b1);
        enable_pin <= 1'b0;
        tick(3);
        enable_pin <= 1'b1;
        tick(8);
        chk("uv clr", fault_status, 19'h0);
    endtask
    task automatic t_pump(input logic dis);
        cfg.pump_uv_disable = dis;
        put();
        pump_uv_in <= 1'b1;
        tick(8);
        outs(dis ? 6'h15 : 6'h00, 1'b1, !dis);
        pump_uv_in <= 1'b0;
        tick(8);
        outs(6'h15, 1'b1, 1'b0);
        chk("pump flag", fault_status.pump_uv_flag, 1'b1);
        clr();
        chk("pump clr", fault_status, 19'h0);
    endtask
    task automatic t_oc(input logic [1:0] m);
        int lim;
        logic f;
        lim = 20 << m;
        f = m != 2'h3;
        cfg = '0;
        cfg.overcurrent_mode = m;
        cfg.overcurrent_deglitch_sel = m;
        put();
        if (m == 2'h3) begin
            cfg.per_phase_oc_disable = 3'h7;
            put();
            apb(1'b0, 12'h004, 32'h0);
            chk("oc lock", q, {11'h0, m, m, 5'h0});
            cfg.per_phase_oc_disable = 3'h0;
        end
        vds_trip_in <= 6'h01;
        tick(lim - 4);
        vds_trip_in <= 6'h00;
        tick(6);
        chk("oc short", fault_status.overcurrent_flag, 1'b0);
        vds_trip_in <= 6'h03;  // bit 1 not driven, must not latch
        tick(lim + 8);
        vds_trip_in <= 6'h00;
        outs(m[1] ? 6'h15 : 6'h00, 1'b1, f);
        chk("oc fet", fault_status.per_fet_oc_flag, {5'h0, f});
        tick(5);
        outs(m[1] ? 6'h15 : 6'h00, 1'b1, f);
        if (m == 2'h1) tick(RC + 6);
        else clr();
        outs(6'h15, 1'b1, 1'b0);
        chk("oc gone", fault_status, 19'h0);
    endtask
    task automatic t_hw();
        vds_trip_in <= 6'h01;
        tick(76);
        vds_trip_in <= 6'h00;
        tick(6);
        chk("hw short", hw_st.overcurrent_flag, 1'b0);
        vds_trip_in <= 6'h01;
        tick(88);
        chk("hw latch", {hw_gv, hw_oe, hw_st.overcurrent_flag}, {6'h00, 2'h3});
        vds_trip_in <= 6'h00;
        clr();
        hw_oc_disable_pin <= 1'b1;
        vds_trip_in <= 6'h01;
        tick(100);
        vds_trip_in <= 6'h00;
        chk("hw off", {hw_gv, hw_oe, hw_st.overcurrent_flag}, {6'h15, 2'h0});
        hw_oc_disable_pin <= 1'b0;
        tick(4);
    endtask
    task automatic t_gdf(input logic [15:0] c);
        cfg = '0;
        {cfg.gate_fault_disable, cfg.bridge_mode, cfg.phase_hb, cfg.phase_fet} = c[15:6];
        put();
        stuck <= 6'h04;
        tick(100);
        outs(c[5:0], 1'b1, !c[15]);
        chk("gate flag", fault_status.per_gate_fault_flag, 6'h04);
        stuck <= 6'h00;
        tick(6);
        clr();
        outs(6'h3f, 1'b1, 1'b0);
        chk("gate clr", fault_status, 19'h0);
    endtask
    task automatic t_therm();
        cfg = '0;
        put();
        otw_in <= 1'b1;
        tick(6);
        outs(6'h3f, 1'b1, 1'b0);
        chk("warn", fault_status.thermal_warning, 1'b1);
        cfg.warn_to_fault_pin = 1'b1;
        put();
        tick(3);
        outs(6'h3f, 1'b1, 1'b1);
        otw_in <= 1'b0;
        tick(6);
        outs(6'h3f, 1'b1, 1'b0);
        chk("warn gone", fault_status, 19'h0);
    endtask
    task automatic t_thermal_shutdown(input logic tm);
        cfg = '0;
        cfg.thermal_recovery_mode = tm;
        put();
        thermal_shutdown_in <= 1'b1;
        tick(8);
        outs(6'h00, 1'b0, 1'b1);
        pump_uv_in <= 1'b1;
        tick(6);
        chk("pump masked", fault_status.pump_uv_flag, 1'b0);
        thermal_shutdown_in <= 1'b0;
        pump_uv_in <= 1'b0;
        tick(8);
        outs(tm ? 6'h3f : 6'h00, tm, !tm);
        chk("thermal_shutdown held", fault_status.thermal_shutdown, 1'b1);
        low_power_pin <= 1'b0;
        tick(3);
        low_power_pin <= 1'b1;
        tick(8);
        outs(6'h3f, 1'b1, 1'b0);
        chk("thermal_shutdown clr", fault_status, 19'h0);
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // main sequence
    initial begin
        tick(20);
        presetn <= 1'b1;
        tick(8);
        t_regs();
        t_sup();
        t_pump(1'b0);
        t_pump(1'b1);
        for (int m = 0; m < 4; m++) begin
            t_oc(m[1:0]);
        end
        t_hw();
        pwm_in <= 6'h3f;
        for (int i = 0; i < 11; i++) begin
            t_gdf(GATE_DRIVE_FAULT[i]);
        end
        t_therm();
        t_thermal_shutdown(1'b0);
        t_thermal_shutdown(1'b1);
        end_of_test();
    end
    // hang guard
    initial begin
        tick(20000);
        err_total++;
        end_of_test();
    end
endmodule
